//--- hdl/port_a_pkg.sv
// Package: register map, reset values and carrier types of the port block
package port_a_pkg;
    localparam int          PORT_WIDTH    = 6;
    localparam int          ADDR_WIDTH    = 8;
    // Register byte offsets
    localparam logic [7:0]  OFF_PIN_LEVELS   = 8'h00;
    localparam logic [7:0]  OFF_OUT_LATCH    = 8'h04;
    localparam logic [7:0]  OFF_DIRECTION    = 8'h08;
    localparam logic [7:0]  OFF_CONV_CONFIG  = 8'h0C;
    localparam logic [7:0]  OFF_COMP_CONTROL = 8'h10;
    // Values after reset
    localparam logic [5:0]  RST_OUT_LATCH    = 6'h00;
    localparam logic [5:0]  RST_DIRECTION    = 6'h3F;
    localparam logic [5:0]  RST_CONV_CONFIG  = 6'h00;
    localparam logic        RST_COMP_REF_OE  = 1'b0;
    // Field positions in the converter configuration register
    localparam int          SEL_LSB          = 0;
    localparam int          SEL_MSB          = 3;
    localparam int          REF_LSB          = 4;
    localparam int          REF_MSB          = 5;
    // Field position of the reference output enable
    localparam int          COMP_REF_OE_BIT  = 0;
    // Pin carrying the timer clock and pin shared with reference output
    localparam int          TIMER_PIN        = 4;
    localparam int          COMP_REF_PIN     = 2;
    // Number of analog channels and of synchroniser stages
    localparam logic [3:0]  ANALOG_CHANNELS  = 4'h5;
    localparam int          SYNC_STAGES      = 2;

    // Drive toward the pad ring
    typedef struct packed {
        logic [PORT_WIDTH-1:0] level;
        logic [PORT_WIDTH-1:0] enable;
    } pin_drive_t;
endpackage : port_a_pkg

//--- hdl/pin_sync.sv
// Two-stage synchroniser for the port input pins
module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] stage_a;
    logic [WIDTH-1:0] stage_b;

    // One flop pair per pin; the first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stage_a[i] <= 1'b0;
                stage_b[i] <= 1'b0;
            end else if (clk_en) begin
                stage_a[i] <= pin_in[i];
                stage_b[i] <= stage_a[i];
            end
        end
    end

    assign pin_sync_out = stage_b;
endmodule // pin_sync

//--- hdl/port_a_gpio.sv
// Six-bit general purpose port with analog sharing and an APB register file
// Summary of operation
// - A pin whose direction bit is 0 is driven from its latch bit, analog use or not.
// - A pin whose direction bit is 1 is read as digital input unless analog is enabled there.
// - After reset pins 0 to 3 and 5 are analog inputs, with no effect on output drive.
// - Pin 4 resets as a digital input and its buffered level also feeds the timer clock.
// - Pin 2 neither drives nor reads while the comparator reference output is enabled.
// - Direction bit n sets pin n; writing 0CFh gives inputs on pins 3 to 0, outputs on 5 and 4.
// - Bits 7 and 6 of levels, latch and direction read 0 and ignore writes.
// - The levels register reads the pins, a write to it loads the latch, the latch reads back.
// - Analog pins read as 0 through the levels register; pin 4 is always digital.
// - Analog or digital use of pins 5 and 3 to 0 follows the 4-bit select field.
module port_a_gpio
    import port_a_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_WIDTH-1:0]     paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [WIDTH-1:0]          pin_in,
    output port_a_pkg::pin_drive_t         pin_drive,
    output logic      [WIDTH-1:0]          analog_enable,
    output logic                           comparator_reference_output,
    output logic                           timer_clock_input
);
    import port_a_pkg::*;

    // Elaboration check: the pin map is fixed at six pins
    if (WIDTH != PORT_WIDTH) begin : g_width_check
        $error("port_a_gpio supports exactly six pins");
    end

    logic [WIDTH-1:0] port_output_latch;
    logic [WIDTH-1:0] port_direction;
    logic [5:0]       converter_pin_config;
    logic             comp_ref_oe;
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_direction;
    logic [5:0]       next_config;
    logic             next_comp_ref_oe;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    pin_drive_t       next_drive;
    logic [WIDTH-1:0] next_analog;
    logic             next_timer_clk;
    logic [WIDTH-1:0] pin_level;
    logic [WIDTH-1:0] analog_sel;
    logic [WIDTH-1:0] input_enable;
    logic [WIDTH-1:0] port_pin_levels;
    logic [3:0]       analog_pin_select;
    logic             acc_done;
    logic             wr_en;
    logic             rd_phase;
    logic             mapped;

    // Pin levels are sampled on pclk before any use
    pin_sync #(
        .WIDTH        (WIDTH)
    ) u_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .clk_en       (clk_en),
        .pin_in       (pin_in),
        .pin_sync_out (pin_level)
    );

    assign analog_pin_select = converter_pin_config[SEL_MSB:SEL_LSB];

    // Analog select decode from the configuration field; code 0 (reset)
    // makes every analog-capable pin analog, five and above none of them
    function automatic logic [WIDTH-1:0] decode_analog(
        input logic [3:0] sel);
        logic [3:0]       count;
        logic [WIDTH-1:0] mask;
        count = (sel > ANALOG_CHANNELS) ? 4'h0 : 4'(ANALOG_CHANNELS - sel);
        mask  = '0;
        // Channels 0 to 3 sit on pins 0 to 3, channel 4 on pin 5
        mask[0] = (count > 4'h0);
        mask[1] = (count > 4'h1);
        mask[2] = (count > 4'h2);
        mask[3] = (count > 4'h3);
        mask[5] = (count > 4'h4);
        return mask; // Pin 4 never analog
    endfunction

    // Per-pin digital input gating; analog use or the reference output
    // blanks the digital read path of its pin
    always_comb begin
        analog_sel   = decode_analog(analog_pin_select);
        input_enable = ~analog_sel;
        if (comp_ref_oe) begin
            input_enable[COMP_REF_PIN] = 1'b0;
        end
        port_pin_levels = pin_level & input_enable;
    end

    // APB access decode; pready is registered, so every access with clk_en
    // held high takes exactly one wait state and acc_done marks the cycle in
    // which the master samples pready high
    always_comb begin
        acc_done = psel && penable && pready;
        wr_en    = acc_done && pwrite;
        rd_phase = psel && penable && !pready;
        case (paddr)
            OFF_PIN_LEVELS, OFF_OUT_LATCH, OFF_DIRECTION,
            OFF_CONV_CONFIG, OFF_COMP_CONTROL: mapped = 1'b1;
            default:                           mapped = 1'b0;
        endcase
    end

    // Register next values; upper bits of each field are dropped
    always_comb begin
        next_latch       = port_output_latch;
        next_direction   = port_direction;
        next_config      = converter_pin_config;
        next_comp_ref_oe = comp_ref_oe;
        if (wr_en && pstrb[0]) begin
            case (paddr)
                OFF_PIN_LEVELS:   next_latch = pwdata[WIDTH-1:0];
                OFF_OUT_LATCH:    next_latch = pwdata[WIDTH-1:0];
                OFF_DIRECTION:    next_direction = pwdata[WIDTH-1:0];
                OFF_CONV_CONFIG:  next_config = pwdata[5:0];
                OFF_COMP_CONTROL: next_comp_ref_oe =
                                      pwdata[COMP_REF_OE_BIT];
                default:          next_latch = port_output_latch;
            endcase
        end
    end

    // Read data and handshake: one wait state, data held with pready
    always_comb begin
        next_pready  = rd_phase;
        next_pslverr = rd_phase && !mapped;
        next_prdata  = prdata;
        if (rd_phase) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    OFF_PIN_LEVELS:   next_prdata[WIDTH-1:0] =
                                          port_pin_levels;
                    OFF_OUT_LATCH:    next_prdata[WIDTH-1:0] =
                                          port_output_latch;
                    OFF_DIRECTION:    next_prdata[WIDTH-1:0] =
                                          port_direction;
                    OFF_CONV_CONFIG:  next_prdata[5:0] = converter_pin_config;
                    OFF_COMP_CONTROL: next_prdata[COMP_REF_OE_BIT] =
                                          comp_ref_oe;
                    default:          next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin drive from next register values so the flop output changes at
    // the very edge that completes the write, with no extra cycle of lag
    always_comb begin
        next_drive.level  = next_latch;
        next_drive.enable = ~next_direction;
        if (next_comp_ref_oe) begin
            next_drive.enable[COMP_REF_PIN] = 1'b0;
        end
        next_analog    = decode_analog(next_config[SEL_MSB:SEL_LSB]);
        next_timer_clk = pin_level[TIMER_PIN];
    end

    // Register file; clk_en low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_latch    <= RST_OUT_LATCH;
            port_direction       <= RST_DIRECTION;
            converter_pin_config <= RST_CONV_CONFIG;
            comp_ref_oe          <= RST_COMP_REF_OE;
        end else if (clk_en) begin
            port_output_latch    <= next_latch;
            port_direction       <= next_direction;
            converter_pin_config <= next_config;
            comp_ref_oe          <= next_comp_ref_oe;
        end
    end

    // Bus response registers; a frozen clock stretches the wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Pin-side outputs; no pin is driven while reset is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive                   <= '0;
            analog_enable               <= '0;
            comparator_reference_output <= 1'b0;
            timer_clock_input           <= 1'b0;
        end else if (clk_en) begin
            pin_drive                   <= next_drive;
            analog_enable               <= next_analog;
            comparator_reference_output <= next_comp_ref_oe;
            timer_clock_input           <= next_timer_clk;
        end
    end
endmodule // port_a_gpio

//--- verif/port_a_gpio_properties.sv
// Checker of the port block's bus timing and pin read-back relations
module port_a_gpio_properties
    import port_a_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  clk_en,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [WIDTH-1:0]      pin_in,
    input wire port_a_pkg::pin_drive_t pin_drive,
    input wire logic [WIDTH-1:0]      analog_enable,
    input wire logic                  comparator_reference_output,
    input wire logic                  timer_clock_input
);
    timeunit 1ns;
    timeprecision 1ns;
    import port_a_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Setup cycle followed by the first access cycle
    sequence setup_then_access;
        psel && !penable && clk_en ##1 psel && penable && clk_en;
    endsequence
    // Completed read of the pin levels register
    sequence levels_read;
        pready && psel && !pwrite && paddr == OFF_PIN_LEVELS;
    endsequence
    a_one_wait_state: assert property (
        setup_then_access |=> pready) else $error("pready not after one wait");
    a_pready_pulse: assert property (
        pready |=> !pready) else $error("pready held too long");
    a_upper_bits_zero: assert property (
        pready && psel && !pwrite && paddr <= OFF_DIRECTION |->
        prdata[31:6] == '0) else $error("upper read bits set");
    a_analog_reads_zero: assert property (
        levels_read |-> (prdata[5:0] & analog_enable) == '0)
        else $error("analog pin read as one");
    a_pin4_digital: assert property (
        !analog_enable[TIMER_PIN]) else $error("pin 4 made analog");
    a_ref_stops_drive: assert property (
        comparator_reference_output |-> !pin_drive.enable[COMP_REF_PIN])
        else $error("pin 2 driven under reference output");
    a_error_with_ready: assert property (
        pslverr |-> pready && psel && penable)
        else $error("pslverr outside a completing access");
    a_timer_lag: assert property (
        clk_en[*3] |=> timer_clock_input == $past(pin_in[TIMER_PIN], 3))
        else $error("timer clock input lag wrong");
    a_levels_follow_pins: assert property (
        ($stable(pin_in) && clk_en)[*4] ##0 levels_read |-> prdata[5:0] ==
        (pin_in & ~analog_enable & ~(6'(comparator_reference_output) << 2)))
        else $error("levels read differs from pins");
endmodule // port_a_gpio_properties

bind port_a_gpio port_a_gpio_properties #(.WIDTH(WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_drive(pin_drive),
    .analog_enable(analog_enable), .timer_clock_input(timer_clock_input),
    .comparator_reference_output(comparator_reference_output));

//--- verif/pin_model.sv
// Board-side model of the six port pins
module pin_model
    import port_a_pkg::*;
(
    input  wire logic                   pclk,
    input  wire port_a_pkg::pin_drive_t drive,
    input  wire logic [5:0]             ext_val,
    input  wire logic [5:0]             ext_en,
    output logic      [5:0]             pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] last = '0;
    // Port driver wins, then the board; a floating pin wanders each cycle
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = drive.enable[i] ? drive.level[i]
                      : ext_en[i] ? ext_val[i] : ~last[i];
        end
    end
    // Last level, inverted while floating
    always_ff @(posedge pclk) begin
        last <= pin_in;
    end
endmodule // pin_model

//--- verif/tb.sv
// Self-checking bench for the six-bit port block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import port_a_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  pin_in, analog_enable, ext_val, ext_en;
    logic        cref, tclk, er, run;
    logic [3:0]  strb;
    pin_drive_t  pin_drive;
    int          err_count, compares;
    // Bus clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    port_a_gpio dut (.pclk(pclk), .presetn(presetn), .clk_en(run),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_drive(pin_drive),
        .analog_enable(analog_enable), .comparator_reference_output(cref),
        .timer_clock_input(tclk));
    pin_model board (.pclk(pclk), .drive(pin_drive), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    // One APB transfer, waiting for pready under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        if (n >= 20) begin err_count++; give_verdict(); end
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(n, e, rd);
    endtask
    task automatic t_reset;
        `CHK("enable", 6'h00, pin_drive.enable);
        `CHK("analog", 6'h2F, analog_enable);
        rchk("latch", OFF_OUT_LATCH, 32'h0000_0000);
        rchk("dir", OFF_DIRECTION, 32'h0000_003F);
        rchk("levels", OFF_PIN_LEVELS, 32'h0000_0010);
        rchk("hole", 8'h20, 32'h0000_0000);
        `CHK("err", 1'b1, er);
        $display("test reset done");
    endtask
    task automatic t_direction;
        bus(1'b1, OFF_OUT_LATCH, 32'h0000_00FF);
        rchk("latch", OFF_OUT_LATCH, 32'h0000_003F);
        bus(1'b1, OFF_DIRECTION, 32'h0000_00CF);
        `CHK("enable", 6'h30, pin_drive.enable);
        `CHK("level", 6'h30, pin_drive.level & 6'h30);
        rchk("dir", OFF_DIRECTION, 32'h0000_000F);
        bus(1'b1, OFF_PIN_LEVELS, 32'h0000_0015);
        rchk("latch", OFF_OUT_LATCH, 32'h0000_0015);
        `CHK("level", 6'h10, pin_drive.level & 6'h30);
        $display("test direction done");
    endtask
    task automatic t_select;
        logic [5:0] m;
        bus(1'b1, OFF_DIRECTION, 32'h0000_003F);
        for (int s = 0; s < 16; s++) begin
            m = '0;
            for (int k = 0; k < 5; k++) if (k < 5 - s) m[k == 4 ? 5 : k] = 1;
            bus(1'b1, OFF_CONV_CONFIG, 32'h0000_0030 | 32'(s));
            `CHK("analog", m, analog_enable);
            rchk("config", OFF_CONV_CONFIG, 32'h0000_0030 | 32'(s));
            rchk("levels", OFF_PIN_LEVELS, 32'(6'h3F & ~m));
        end
        $display("test select done");
    endtask
    task automatic t_cref;
        bus(1'b1, OFF_DIRECTION, 32'h0000_0000);
        `CHK("enable", 6'h3F, pin_drive.enable);
        bus(1'b1, OFF_COMP_CONTROL, 32'h0000_0001);
        `CHK("enable", 6'h3B, pin_drive.enable);
        `CHK("cref", 1'b1, cref);
        bus(1'b1, OFF_DIRECTION, 32'h0000_003F);
        repeat (4) @(posedge pclk);
        rchk("levels", OFF_PIN_LEVELS, 32'h0000_003B);
        bus(1'b1, OFF_COMP_CONTROL, 32'h0000_0000);
        `CHK("cref", 1'b0, cref);
        rchk("levels", OFF_PIN_LEVELS, 32'h0000_003F);
        $display("test reference done");
    endtask
    task automatic t_timer;
        for (int v = 0; v < 2; v++) begin
            ext_val[4] <= v[0];
            repeat (4) @(posedge pclk);
            `CHK("timer", v[0], tclk);
        end
        $display("test timer done");
    endtask
    // Clock enable low freezes the synchroniser and the timer output
    task automatic t_freeze;
        run <= 1'b0;
        ext_val[4] <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK("frozen", 1'b1, tclk);
        run <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("thawed", 1'b0, tclk);
        $display("test freeze done");
    endtask
    // Writes with byte lane 0 off or to a hole leave the latch alone
    task automatic t_refuse;
        bus(1'b1, OFF_OUT_LATCH, 32'h0000_002A);
        strb <= 4'h0;
        bus(1'b1, OFF_OUT_LATCH, 32'h0000_0015);
        strb <= 4'hF;
        rchk("latch", OFF_OUT_LATCH, 32'h0000_002A);
        `CHK("err", 1'b0, er);
        bus(1'b1, 8'h20, 32'h0000_0015);
        `CHK("err", 1'b1, er);
        rchk("latch", OFF_OUT_LATCH, 32'h0000_002A);
        $display("test refuse done");
    endtask
    // A reset in mid-run brings every register back to its default
    task automatic t_rerun;
        bus(1'b1, OFF_DIRECTION, 32'h0000_0000);
        bus(1'b1, OFF_COMP_CONTROL, 32'h0000_0001);
        `CHK("enable", 6'h3B, pin_drive.enable);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("enable", 6'h00, pin_drive.enable);
        `CHK("analog", 6'h2F, analog_enable);
        `CHK("cref", 1'b0, cref);
        rchk("latch", OFF_OUT_LATCH, 32'h0000_0000);
        rchk("dir", OFF_DIRECTION, 32'h0000_003F);
        rchk("config", OFF_CONV_CONFIG, 32'h0000_0000);
        $display("test reset again done");
    endtask
    task automatic give_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; ext_val = '1; ext_en = '1; err_count = 0; compares = 0;
        run = 1'b1; strb = 4'hF;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_direction();
        t_select();
        t_cref();
        t_timer();
        t_freeze();
        t_refuse();
        t_rerun();
        give_verdict();
    end
endmodule // tb
